// [bench/lcst_cell_tb_top.sv]
// Self-checking testbench of the logic cell storage and bus buffers.
`timescale 1ns/10ps
module lcst_cell_tb_top;
   import lcst_pkg::*;
   logic clk = 1'b0, rst = 1'b1, gr_pin = 1'b0, gr_node = 1'b0;
   logic shared_clock = 1'b0, clock_enable = 1'b1, async_clear = 1'b0;
   logic block_output_enable = 1'b1;
   logic [3:0] lut_out = 4'hA, direct_data_in = 4'h5, bus_in = 4'h0;
   logic [3:0] far_en = 4'h0, far_val = 4'h0;
   logic [3:0] stored_q, direct_data_out, comb_out, bus_out, bus_oe, bus_kept;
   logic global_reset_net;
   lcst_cfg_s cfg = '0;
   lcst_bus_s bus_other;
   int mismatches = 0, comparisons = 0, cycles = 0;
   lcst_cell dut (.clk(clk), .rst(rst), .cfg(cfg), .gr_pin(gr_pin),
      .gr_node(gr_node), .shared_clock(shared_clock),
      .clock_enable(clock_enable), .async_clear(async_clear),
      .lut_out(lut_out), .direct_data_in(direct_data_in), .bus_in(bus_in),
      .block_output_enable(block_output_enable), .bus_other(bus_other),
      .stored_q(stored_q), .direct_data_out(direct_data_out),
      .comb_out(comb_out), .bus_out(bus_out), .bus_oe(bus_oe),
      .bus_kept(bus_kept), .global_reset_net(global_reset_net));
   lcst_far_end far (.clk(clk), .rst(rst), .drive_en(far_en),
      .drive_val(far_val), .bus(bus_other));
   // ----------------------------------------------------------------------
   // Clock, timeout and helpers
   // ----------------------------------------------------------------------
   // The run needs about a hundred cycles; the ceiling leaves a wide margin.
   initial
   begin
      forever #4 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         mismatches++;
         results();
      end
   end
   task automatic check(input string name, input logic [7:0] seen,
                        input logic [7:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // Inputs change 1 ns after the edge, clear of the sampling instant.
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // One low-then-high cycle of the block clock, each level held long.
   task automatic pulse();
      shared_clock = 1'b0;
      step(3);
      shared_clock = 1'b1;
      step(3);
   endtask
   task automatic results();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // ----------------------------------------------------------------------
   // Test sequence
   // ----------------------------------------------------------------------
   initial
   begin
      step(9);
      check("q in reset", stored_q, 4'h0);
      check("net in reset", {3'h0, global_reset_net}, 4'h1);
      check("keep in reset", bus_kept, 4'h0);
      step(1);
      rst = 1'b0;
      step(2);
      check("feedthrough", direct_data_out, 4'h5);
      check("comb out", comb_out, 4'hA);
      pulse();
      check("ff table", stored_q, 4'hA);
      cfg.src_direct = 4'h3;
      pulse();
      check("ff mixed src", stored_q, 4'h9);
      cfg.src_direct = 4'h0;
      lut_out = 4'h6;
      clock_enable = 1'b0;
      pulse();
      check("enable low", stored_q, 4'h9);
      cfg.ce_unused = 4'h1;
      pulse();
      check("open enable", stored_q, 4'h8);
      clock_enable = 1'b1;
      cfg.ce_unused = 4'h0;
      cfg.falling_edge = 4'hF;
      lut_out = 4'h3;
      step(3);
      check("no rise", stored_q, 4'h8);
      shared_clock = 1'b0;
      step(3);
      check("falling edge", stored_q, 4'h3);
      cfg.falling_edge = 4'h0;
      cfg.latch_mode = 4'hF;
      shared_clock = 1'b1;
      lut_out = 4'hC;
      step(3);
      check("latch hold", stored_q, 4'h3);
      shared_clock = 1'b0;
      step(3);
      check("latch open", stored_q, 4'hC);
      lut_out = 4'h4;
      step(3);
      check("latch follow", stored_q, 4'h4);
      clock_enable = 1'b0;
      lut_out = 4'hF;
      step(3);
      check("latch enable", stored_q, 4'h4);
      clock_enable = 1'b1;
      shared_clock = 1'b1;
      step(3);
      cfg.latch_mode = 4'h0;
      pulse();
      check("reload", stored_q, 4'hF);
      cfg.clr_disable = 4'h5;
      async_clear = 1'b1;
      #1;
      check("clear now", stored_q, 4'h5);
      step(1);
      pulse();
      check("clear wins", stored_q, 4'h5);
      async_clear = 1'b0;
      step(2);
      check("after clear", stored_q, 4'h5);
      cfg.clr_disable = 4'h0;
      pulse();
      cfg.gr_from_node = 1'b1;
      gr_node = 1'b1;
      #1;
      check("node reset", {global_reset_net, stored_q}, 5'h10);
      step(1);
      gr_node = 1'b0;
      step(2);
      check("node idle", {global_reset_net, stored_q}, 5'h00);
      cfg.gr_invert = 1'b1;
      #1;
      check("inverted", {3'h0, global_reset_net}, 4'h1);
      step(1);
      cfg.gr_invert = 1'b0;
      cfg.gr_from_node = 1'b0;
      gr_pin = 1'b1;
      step(3);
      check("pin reset", {3'h0, global_reset_net}, 4'h1);
      gr_pin = 1'b0;
      step(3);
      check("pin idle", {3'h0, global_reset_net}, 4'h0);
      cfg.buf_always = 4'h3;
      bus_in = 4'hF;
      #1;
      check("oe floated", bus_oe, 4'h3);
      check("buf data", bus_out, 4'hF);
      step(2);
      check("keep partial", bus_kept, 4'h3);
      block_output_enable = 1'b0;
      #1;
      check("oe shared", bus_oe, 4'hF);
      step(2);
      check("keep all", bus_kept, 4'hF);
      block_output_enable = 1'b1;
      bus_in = 4'h0;
      step(2);
      check("keep held", bus_kept, 4'hC);
      far_en = 4'h8;
      step(2);
      check("other drives", bus_kept, 4'h4);
      far_en = 4'h0;
      step(3);
      check("other gone", bus_kept, 4'h4);
      results();
   end
endmodule

// [bench/lcst_far_end.sv]
// Model of the other blocks that share the long bus lines.
`timescale 1ns/10ps
module lcst_far_end
(
   input  wire logic           clk,
   input  wire logic           rst,
   input  wire logic [3:0]     drive_en,
   input  wire logic [3:0]     drive_val,
   output lcst_pkg::lcst_bus_s bus
);
   import lcst_pkg::*;
   logic [3:0] last;
   // ----------------------------------------------------------------------
   // Line levels
   // ----------------------------------------------------------------------
   // Remember the last level this model drove on each line.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         last <= 4'h0;
      end
      else
      begin
         last <= (drive_en & drive_val) | (~drive_en & last);
      end
   end
   // A released line shows the inverse of its last level, so a keeper that
   // copies the wire instead of holding its own value is caught.
   assign bus = {(drive_en & drive_val) | (~drive_en & ~last), drive_en};
endmodule

// [design/lcst_cell.sv]
// Storage elements and bus buffers of one programmable logic block.
`timescale 1ns/10ps

// What this block does
// RULE_01: Global reset forces every element to zero.
// RULE_02: Shared active-high clear zeroes elements immediately.
// RULE_03: Per-element setting can disconnect the clear.
// RULE_04: Flip-flop loads data on edge when enabled.
// RULE_05: Latch passes data while clock inactive-low.
// RULE_06: Low shared enable holds every element.
// RULE_07: Unconnected enable behaves as always active.
// RULE_08: Unconnected clear defaults to inactive low.
// RULE_09: Shared clock, per-element edge polarity.
// RULE_10: Clear and enable are never inverted.
// RULE_11: Data source selects table or direct input.
// RULE_12: Four direct inputs feed through to outputs.
// RULE_13: Combinational output always comes from table.
// RULE_14: Global reset from pin or node, invertible.
// RULE_15: Each bus buffer always-drive or three-state.
// RULE_16: Three-state buffers share the block enable.
// RULE_17: Control one floats buffer, zero passes input.
// RULE_18: Weak keeper on lines, drivers override it.
// RULE_19: Undriven line keeps last driven value.
module lcst_cell
(
   input  wire logic               clk,
   input  wire logic               rst,
   input  wire lcst_pkg::lcst_cfg_s cfg,
   input  wire logic               gr_pin,
   input  wire logic               gr_node,
   input  wire logic               shared_clock,
   input  wire logic               clock_enable,
   input  wire logic               async_clear,
   input  wire logic [3:0]         lut_out,
   input  wire logic [3:0]         direct_data_in,
   input  wire logic [3:0]         bus_in,
   input  wire logic               block_output_enable,
   input  wire lcst_pkg::lcst_bus_s bus_other,
   output logic [3:0]              stored_q,
   output logic [3:0]              direct_data_out,
   output logic [3:0]              comb_out,
   output logic [3:0]              bus_out,
   output logic [3:0]              bus_oe,
   output logic [3:0]              bus_kept,
   output logic                    global_reset_net
);
   import lcst_pkg::*;

   // ----------------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------------
   logic [1:0] gr_sync;
   logic [1:0] next_gr_sync;
   logic       prev_clock;
   logic       next_prev_clock;
   logic [3:0] q;
   logic [3:0] next_q;
   logic [3:0] keep;
   logic [3:0] next_keep;
   logic [3:0] eff_clock;
   logic [3:0] eff_prev;
   logic [3:0] rise;
   logic [3:0] ce_eff;
   logic [3:0] clr_hit;
   logic [3:0] kill;
   logic [3:0] d_sel;
   logic       gr_src;

   // Element polarity applied to a sampled clock level.
   function automatic logic [3:0] polar(input logic lvl, input logic [3:0] f);
      polar = {4{lvl}} ^ f;
   endfunction

   // ----------------------------------------------------------------------
   // Global reset source
   // ----------------------------------------------------------------------
   // The pin passes two flip-flops before anything looks at it.
   always_comb
   begin
      next_gr_sync = {gr_sync[0], gr_pin};
   end

   // Two stages settle a pin that may change at any moment; only the
   // second stage is read, which costs two cycles of reset latency.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         gr_sync <= LCST_SYNC_RESET;
      else
         gr_sync <= next_gr_sync;
   end

   // Source choice and optional inversion ahead of the reset network.
   always_comb
   begin
      gr_src = cfg.gr_from_node ? gr_node : gr_sync[1];                 // RULE_14
      global_reset_net = rst | (gr_src ^ cfg.gr_invert);                // RULE_14
   end

   // ----------------------------------------------------------------------
   // Shared controls
   // ----------------------------------------------------------------------
   // Clear and enable enter uninverted; only the active-high sense exists.
   // An open enable is modelled as a per-element tie to active, and an
   // open clear as the element's clear being disconnected.
   always_comb
   begin
      eff_clock = polar(shared_clock, cfg.falling_edge);                // RULE_09
      eff_prev  = polar(prev_clock, cfg.falling_edge);                  // RULE_09
      rise      = eff_clock & ~eff_prev;
      ce_eff    = {4{clock_enable}} | cfg.ce_unused;            // RULE_06 RULE_07 RULE_10
      clr_hit   = {4{async_clear}} & ~cfg.clr_disable;  // RULE_02 RULE_03 RULE_08 RULE_10
      kill      = clr_hit | {4{global_reset_net}};              // RULE_01 RULE_02
      d_sel     = (cfg.src_direct & direct_data_in)
                | (~cfg.src_direct & lut_out);                          // RULE_11
   end

   // ----------------------------------------------------------------------
   // Storage elements
   // ----------------------------------------------------------------------
   // The shared clock is a logic signal sampled on clk; edges are seen
   // one cycle late, which is the price of staying in one clock domain.
   always_comb
   begin
      next_prev_clock = shared_clock;
      next_q = q;
      for (int i = 0; i < LCST_NUM_ELEM; i++)
      begin
         if (kill[i])
            next_q[i] = 1'b0;                                   // RULE_01 RULE_02
         else if (!ce_eff[i])
            next_q[i] = q[i];                                           // RULE_06
         else if (cfg.latch_mode[i])
            next_q[i] = eff_clock[i] ? q[i] : d_sel[i];                 // RULE_05
         else if (rise[i])
            next_q[i] = d_sel[i];                                       // RULE_04
      end
   end

   // Registers only; clear and global reset priority live in next_q, so
   // the asynchronous branch loads nothing but constants.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         q          <= LCST_STORE_RESET;
         prev_clock <= 1'b0;
      end
      else
      begin
         q          <= next_q;
         prev_clock <= next_prev_clock;
      end
   end

   // Clear and global reset act at once on the visible output, not only
   // at the next sample, so no stale one escapes during a clear.
   assign stored_q = q & ~kill;                                 // RULE_01 RULE_02

   // ----------------------------------------------------------------------
   // Bypass and combinational outputs
   // ----------------------------------------------------------------------
   // Pure wires: neither path passes through storage, so both follow
   // their inputs in the same cycle whatever the element settings are.
   assign direct_data_out = direct_data_in;                             // RULE_12
   assign comb_out        = lut_out;                                    // RULE_13

   // ----------------------------------------------------------------------
   // Bus buffers and keepers
   // ----------------------------------------------------------------------
   // Only this block's buffers and one lumped view of the other drivers
   // are modelled; two drivers fighting over a line are not resolved.
   // The control is an active-high three-state, i.e. a low enable.
   always_comb
   begin
      bus_out = bus_in;                                                 // RULE_17
      bus_oe  = cfg.buf_always | ~{4{block_output_enable}}; // RULE_15 RULE_16 RULE_17
   end

   // The keeper only follows real drivers, so an idle line never floats.
   always_comb
   begin
      next_keep = keep;
      for (int i = 0; i < LCST_NUM_ELEM; i++)
      begin
         if (bus_oe[i])
            next_keep[i] = bus_out[i];                                  // RULE_18
         else if (bus_other.drive[i])
            next_keep[i] = bus_other.data[i];                           // RULE_18
      end
   end

   // The kept level starts low after power-up; a line that nobody has
   // driven yet therefore reads as zero, not as an unknown.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         keep <= LCST_KEEP_RESET;
      else
         keep <= next_keep;                                             // RULE_19
   end

   // The kept level is registered, so it trails a new driver by one cycle.
   assign bus_kept = keep;

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   // Every check samples on clk and rests while power-up reset is high.
   // The shared clock is data here, so its edges are judged from its
   // sampled history, just as the storage logic itself sees them.
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   for (genvar g = 0; g < LCST_NUM_ELEM; g++)
   begin : g_chk
      // Reset and clear force zero; the clear only where it is connected.
      a_global_reset_zero: assert property ( // RULE_01
         global_reset_net |-> (stored_q[g] == 1'b0) ##1 (q[g] == 1'b0))
         else $error("Global reset did not clear element.");
      a_clear_forces_zero: assert property ( // RULE_02
         (async_clear && !cfg.clr_disable[g]) |-> stored_q[g] == 1'b0)
         else $error("Clear did not force element to zero.");
      a_clear_next_zero: assert property ( // RULE_02
         (async_clear && !cfg.clr_disable[g]) |=> q[g] == 1'b0)
         else $error("Clear did not reach the stored bit.");
      a_clear_disconnected: assert property ( // RULE_03
         (async_clear && cfg.clr_disable[g] && !global_reset_net)
         |-> stored_q[g] == q[g])
         else $error("Disconnected clear still acted.");

      // Flip-flop loading, holding, polarity and data source.
      a_ff_edge_load: assert property ( // RULE_04
         (!cfg.latch_mode[g] && rise[g] && ce_eff[g] && !kill[g])
         |=> q[g] == $past(d_sel[g]))
         else $error("Flip-flop missed data on its edge.");
      a_ff_idle_hold: assert property ( // RULE_04
         (!cfg.latch_mode[g] && !rise[g] && !kill[g]) |=> $stable(q[g]))
         else $error("Flip-flop changed without an edge.");
      a_ff_falling_load: assert property ( // RULE_09
         (!cfg.latch_mode[g] && cfg.falling_edge[g] && ce_eff[g]
          && !kill[g] && !shared_clock && $past(shared_clock)
          && !$past(rst)) |=> q[g] == $past(d_sel[g]))
         else $error("Falling-edge element missed its edge.");
      a_ff_source_select: assert property ( // RULE_11
         (!cfg.latch_mode[g] && rise[g] && ce_eff[g] && !kill[g])
         |=> q[g] == ($past(cfg.src_direct[g]) ? $past(direct_data_in[g])
                      : $past(lut_out[g])))
         else $error("Flip-flop loaded from the wrong source.");
      a_open_enable_load: assert property ( // RULE_07
         (cfg.ce_unused[g] && !clock_enable && !cfg.latch_mode[g]
          && rise[g] && !kill[g]) |=> q[g] == $past(d_sel[g]))
         else $error("Open enable did not act as active.");

      // Latch transparency and the shared enable.
      a_latch_hold_pass: assert property ( // RULE_05
         (cfg.latch_mode[g] && ce_eff[g] && !kill[g])
         |=> q[g] == ($past(eff_clock[g]) ? $past(q[g]) : $past(d_sel[g])))
         else $error("Latch did not pass or hold correctly.");
      a_enable_low_hold: assert property ( // RULE_06
         (!clock_enable && !cfg.ce_unused[g] && !kill[g]) |=> $stable(q[g]))
         else $error("Element changed while enable low.");

      // Bus buffer enables and the keeper of each line.
      a_buffer_always_on: assert property ( // RULE_15
         cfg.buf_always[g] |-> bus_oe[g])
         else $error("Always-driving buffer was released.");
      a_buffer_shared_oe: assert property ( // RULE_16
         !cfg.buf_always[g] |-> bus_oe[g] == !block_output_enable)
         else $error("Three-state buffer ignored the block enable.");
      a_keeper_own_drive: assert property ( // RULE_18
         bus_oe[g] |=> bus_kept[g] == $past(bus_in[g]))
         else $error("Keeper did not follow this block's driver.");
      a_keeper_other_drive: assert property ( // RULE_18
         (!bus_oe[g] && bus_other.drive[g])
         |=> bus_kept[g] == $past(bus_other.data[g]))
         else $error("Keeper did not follow another driver.");
      a_keeper_holds: assert property ( // RULE_19
         (!bus_oe[g] && !bus_other.drive[g]) |=> $stable(bus_kept[g]))
         else $error("Undriven line lost its kept level.");
   end

   a_buffer_enable: assert property ( // RULE_17
      bus_oe == (cfg.buf_always | {4{!block_output_enable}})
      && (bus_oe & bus_out) == (bus_oe & bus_in))
      else $error("Bus buffer enable or data wrong.");
   a_feedthrough_copy: assert property ( // RULE_12 RULE_13
      direct_data_out == direct_data_in && comb_out == lut_out)
      else $error("Bypass or table output differs from its source.");
   a_pin_reset_path: assert property ( // RULE_14
      (!cfg.gr_from_node && !$past(rst) && !$past(rst, 2))
      |-> global_reset_net == ($past(gr_pin, 2) ^ cfg.gr_invert))
      else $error("Pin reset did not reach the reset network.");

   // Scenarios worth seeing at least once in a run.
   c_ff_load: cover property (
      !cfg.latch_mode[0] && rise[0] && ce_eff[0] && !kill[0] ##1 q[0]);
   c_latch_pass: cover property (
      cfg.latch_mode[2] && !eff_clock[2] && ce_eff[2] && d_sel[2]
      && !kill[2] ##1 q[2]);
   c_clear_hit: cover property (q[3] ##0 clr_hit[3]);
   c_bus_float: cover property (
      !bus_oe[3] ##1 bus_other.drive[3] ##1 !bus_other.drive[3]);
   c_pin_reset: cover property (!cfg.gr_from_node && global_reset_net);

endmodule

// [design/lcst_pkg.sv]
// Package of shared constants and carrier types for the logic cell storage.
package lcst_pkg;

   // ----------------------------------------------------------------------
   // Sizes and reset values
   // ----------------------------------------------------------------------
   localparam int         LCST_NUM_ELEM    = 4;
   localparam logic [3:0] LCST_STORE_RESET = 4'h0;
   localparam logic [3:0] LCST_KEEP_RESET  = 4'h0;
   localparam logic [1:0] LCST_SYNC_RESET  = 2'h0;

   // ----------------------------------------------------------------------
   // Configuration carried as one packed word
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic [3:0] latch_mode;    // 1: element is a transparent latch.
      logic [3:0] falling_edge;  // 1: element triggers on the falling edge.
      logic [3:0] clr_disable;   // 1: element ignores the shared clear.
      logic [3:0] ce_unused;     // 1: enable left open, treated as active.
      logic [3:0] src_direct;    // 1: data from direct input, else table.
      logic [3:0] buf_always;    // 1: bus buffer always drives.
      logic       gr_from_node;  // 1: global reset from internal node.
      logic       gr_invert;     // 1: invert the global reset source.
   } lcst_cfg_s;

   // ----------------------------------------------------------------------
   // Long bus line signals of one block
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic [3:0] data;          // Level driven or observed per line.
      logic [3:0] drive;         // Per line: a driver is active.
   } lcst_bus_s;

endpackage
